// [pbm_pkg.sv]
// Package for the port B pins 6..0 alternate-function mux
package pbm_pkg;

  // ---------------------------------------------------------------
  // Pin positions
  // ---------------------------------------------------------------
  localparam int PBM_NPINS = 7;
  localparam int PBM_PIN_CNT0 = 0;
  localparam int PBM_PIN_CNT1 = 1;
  localparam int PBM_PIN_IRQ2 = 2;
  localparam int PBM_PIN_CMPA = 3;
  localparam int PBM_PIN_SEL = 4;
  localparam int PBM_PIN_MOSI = 5;
  localparam int PBM_PIN_MISO = 6;
  localparam int PBM_NPCH = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [PBM_NPINS-1:0] PBM_PAD_RST = 7'h00;
  localparam logic [PBM_NPINS-1:0] PBM_DIE_RST = 7'h7F;
  localparam logic PBM_SEL_N_RST = 1'b1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PBM_SPI_OFF    = 3'b001,
    PBM_SPI_SLAVE  = 3'b010,
    PBM_SPI_MASTER = 3'b100
  } pbm_spi_role_e;

  // Port data-direction and output register bits
  typedef struct packed {
    logic [PBM_NPINS-1:0] dir;
    logic [PBM_NPINS-1:0] out;
  } pbm_port_s;

  // Pad controls: pull-up, output enable, output value, input enable
  typedef struct packed {
    logic [PBM_NPINS-1:0] pu;
    logic [PBM_NPINS-1:0] oe;
    logic [PBM_NPINS-1:0] pv;
    logic [PBM_NPINS-1:0] die;
  } pbm_pad_s;

  // Inputs handed to peripherals
  typedef struct packed {
    logic [PBM_NPCH-1:0] pin_change;
    logic external_irq_two;
    logic counter_one_ext_input;
    logic counter_zero_ext_input;
    logic usart_zero_sync_clock;
    logic sel_n;
    logic slave_active;
    logic master_in;
    logic slave_in;
  } pbm_per_s;

  typedef struct packed {
    pbm_pad_s pad;
    pbm_per_s per;
  } pbm_state_s;

endpackage : pbm_pkg

// [pbm_mux.sv]
// Port B pins 6..0 alternate-function override mux
`timescale 1ns/1ps

// How it works
// (R1) SPI slave forces select pin 4 to input, ignoring its direction bit.
// (R2) Slave SPI is active only while select pin 4 is low.
// (R3) SPI master leaves pin 4 direction to its direction bit.
// (R4) Forced-input select pin keeps pull-up from its port output bit.
// (R5) Timer 0 compare B drives pin 4 only when pin 4 is output.
// (R6) Timer 0 compare A drives pin 3 only when pin 3 is output.
// (R7) Pins 4..0 feed pin-change sources 12..8.
// (R8) Pin 2 also feeds external interrupt two.
// (R9) Pin 1 feeds the timer 1 external count input.
// (R10) Pin 0 feeds the timer 0 external count input.
// (R11) Clock-output fuse drives divided clock on pin 1, overriding port bits.
// (R12) With the fuse set, pin 1 keeps the clock during reset.
// (R13) Serial port zero clock on pin 0: out if direction one, else in.
// (R14) Pin 0 clock function works only in synchronous mode.
// (R15) MISO: master input, slave output; MOSI: master output, slave input.
// (R16) SPI master forces MISO pin 6 to input.
// (R17) Any asserted override enable replaces the register-derived pad value.
// (R18) Each pin input reaches all its sharing functions at once.
module pbm_mux
  import pbm_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // Port registers
  input  wire pbm_port_s port_i,
  input  wire logic pull_up_disable_i,
  input  wire logic sleep_input_off_i,
  // Pads
  input  wire logic [PBM_NPINS-1:0] pad_in_i,
  output pbm_pad_s pad_o,
  // SPI
  input  wire logic spi_en_i,
  input  wire logic spi_master_i,
  input  wire logic spi_master_out_i,
  input  wire logic spi_slave_out_i,
  // Timer 0 compare outputs
  input  wire logic timer_zero_compare_a_en_i,
  input  wire logic timer_zero_compare_a_out_i,
  input  wire logic timer_zero_compare_b_en_i,
  input  wire logic timer_zero_compare_b_out_i,
  // Interrupt enables
  input  wire logic pin_change_group_en_i,
  input  wire logic [PBM_NPCH-1:0] pin_change_mask_i,
  input  wire logic external_irq_two_en_i,
  // Clock output and serial port zero
  input  wire logic clock_output_fuse_i,
  input  wire logic divided_sysclk_out_i,
  input  wire logic serial_port_zero_sync_i,
  input  wire logic usart_zero_sync_clock_out_i,
  // Peripheral inputs
  output pbm_per_s per_o
);

  // ---------------------------------------------------------------
  // Override terms
  // ---------------------------------------------------------------
  pbm_spi_role_e role;
  logic slave;
  logic master;
  logic [PBM_NPINS-1:0] puoe, puov, ddoe, ddov, pvoe, pvov, dieoe, dieov;
  pbm_pad_s eff;
  pbm_state_s s_q, s_d;
  logic [1:0] clk_pin_q;
  logic [PBM_NPINS-1:0] din;

  always_comb begin
    unique case ({spi_en_i, spi_master_i})
      2'b10: role = PBM_SPI_SLAVE;
      2'b11: role = PBM_SPI_MASTER;
      default: role = PBM_SPI_OFF;
    endcase
  end
  assign slave = (role == PBM_SPI_SLAVE);
  assign master = (role == PBM_SPI_MASTER);

  // Pull-up keeps following port bit while direction is forced [R4]
  assign puoe = {master, slave, slave, 4'h0};
  assign puov = {port_i.out[PBM_PIN_MISO] & ~pull_up_disable_i,
                 port_i.out[PBM_PIN_MOSI] & ~pull_up_disable_i,
                 port_i.out[PBM_PIN_SEL] & ~pull_up_disable_i, 4'h0};
  // Slave forces pin 4 and MOSI in, master forces MISO in [R1] [R16] [R3]
  // Fuse forces pin 1 out [R11]
  assign ddoe = {master, slave, slave, 2'h0, clock_output_fuse_i, 1'b0};
  assign ddov = {3'h0, 2'h0, clock_output_fuse_i, 1'b0};
  // Output values; direction still comes from the direction bit [R5] [R6]
  assign pvoe = {slave, master, timer_zero_compare_b_en_i,
                 timer_zero_compare_a_en_i, 1'b0, clock_output_fuse_i,
                 serial_port_zero_sync_i}; // [R11] [R13] [R14] [R15]
  assign pvov = {spi_slave_out_i, spi_master_out_i,
                 timer_zero_compare_b_out_i, timer_zero_compare_a_out_i,
                 1'b0, divided_sysclk_out_i, usart_zero_sync_clock_out_i};
  // Enabled interrupt inputs stay alive in sleep
  assign dieoe = {2'h0, pin_change_mask_i & {PBM_NPCH{pin_change_group_en_i}}}
                 | {4'h0, external_irq_two_en_i, 2'h0};
  assign dieov = {PBM_NPINS{1'b1}};

  // ---------------------------------------------------------------
  // Per-pin override application
  // ---------------------------------------------------------------
  for (genvar i = 0; i < PBM_NPINS; i++) begin : g_pin
    logic pu_reg;
    assign pu_reg = port_i.out[i] & ~port_i.dir[i] & ~pull_up_disable_i;
    assign eff.pu[i] = puoe[i] ? puov[i] : pu_reg; // [R17]
    assign eff.oe[i] = ddoe[i] ? ddov[i] : port_i.dir[i]; // [R17]
    assign eff.pv[i] = pvoe[i] ? pvov[i] : port_i.out[i]; // [R17]
    assign eff.die[i] = dieoe[i] ? dieov[i] : ~sleep_input_off_i; // [R17]
    assign din[i] = pad_in_i[i] & eff.die[i];
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.pad = eff;
    // One gated input fans out to every sharing function except slave_active, which takes the raw pad [R18]
    s_d.per.pin_change = din[PBM_NPCH-1:0]; // [R7]
    s_d.per.external_irq_two = din[PBM_PIN_IRQ2]; // [R8]
    s_d.per.counter_one_ext_input = din[PBM_PIN_CNT1]; // [R9]
    s_d.per.counter_zero_ext_input = din[PBM_PIN_CNT0]; // [R10]
    s_d.per.usart_zero_sync_clock = serial_port_zero_sync_i
        & ~port_i.dir[PBM_PIN_CNT0] & din[PBM_PIN_CNT0]; // [R13] [R14]
    s_d.per.sel_n = din[PBM_PIN_SEL];
    // Raw pad level: a sleeping input must not read as a low select
    s_d.per.slave_active = slave & ~pad_in_i[PBM_PIN_SEL]; // [R2]
    s_d.per.master_in = master & din[PBM_PIN_MISO]; // [R15]
    s_d.per.slave_in = slave & din[PBM_PIN_MOSI]; // [R15]
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q.pad.pu <= PBM_PAD_RST;
      s_q.pad.oe <= PBM_PAD_RST;
      s_q.pad.pv <= PBM_PAD_RST;
      s_q.pad.die <= PBM_DIE_RST;
      s_q.per <= '0;
      s_q.per.sel_n <= PBM_SEL_N_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Pin 1 flop has no reset so the clock keeps running through reset
  always_ff @(posedge ref_clk_i) begin
    clk_pin_q <= {eff.oe[PBM_PIN_CNT1], eff.pv[PBM_PIN_CNT1]}; // [R12]
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign pad_o.pu = s_q.pad.pu;
  assign pad_o.die = s_q.pad.die;
  assign pad_o.oe = {s_q.pad.oe[PBM_NPINS-1:2], clk_pin_q[1],
                     s_q.pad.oe[0]};
  assign pad_o.pv = {s_q.pad.pv[PBM_NPINS-1:2], clk_pin_q[0],
                     s_q.pad.pv[0]};
  assign per_o = s_q.per;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  // First edge after reset still shows reset values, so checks wait two
  logic [1:0] chk_live_q;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chk_live_q <= 2'h0;
    end else begin
      chk_live_q <= {chk_live_q[0], 1'h1};
    end
  end
  default disable iff (rst_i || !chk_live_q[1]);

  sequence slave_seen;
    $past(spi_en_i) && !$past(spi_master_i);
  endsequence
  sequence master_seen;
    $past(spi_en_i) && $past(spi_master_i);
  endsequence

  a_sel_forced_in: assert property ( // [R1]
    slave_seen |-> !pad_o.oe[PBM_PIN_SEL])
    else $error("select pin driven in slave mode");
  a_sel_master_dir: assert property ( // [R3]
    master_seen |-> pad_o.oe[PBM_PIN_SEL] == $past(port_i.dir[PBM_PIN_SEL]))
    else $error("select pin direction not from direction bit");
  a_sel_pull_up: assert property ( // [R4]
    slave_seen |-> pad_o.pu[PBM_PIN_SEL] ==
      ($past(port_i.out[PBM_PIN_SEL]) && !$past(pull_up_disable_i)))
    else $error("select pin pull-up wrong");
  a_slave_active: assert property ( // [R2]
    slave_seen and $past(pad_in_i[PBM_PIN_SEL]) |-> !per_o.slave_active)
    else $error("slave active with select high");
  a_cmp_b_out: assert property ( // [R5]
    $past(timer_zero_compare_b_en_i) && !$past(slave) |->
      pad_o.pv[PBM_PIN_SEL] == $past(timer_zero_compare_b_out_i)
      && pad_o.oe[PBM_PIN_SEL] == $past(port_i.dir[PBM_PIN_SEL]))
    else $error("compare B not on pin 4");
  a_cmp_a_out: assert property ( // [R6]
    $past(timer_zero_compare_a_en_i) |->
      pad_o.pv[PBM_PIN_CMPA] == $past(timer_zero_compare_a_out_i)
      && pad_o.oe[PBM_PIN_CMPA] == $past(port_i.dir[PBM_PIN_CMPA]))
    else $error("compare A not on pin 3");
  a_pin_change: assert property ( // [R7]
    $past(pad_o.die == PBM_DIE_RST) ##1 1'b1 |->
      per_o.pin_change == ($past(pad_in_i[PBM_NPCH-1:0])
        & (($past(pin_change_mask_i)
            & {PBM_NPCH{$past(pin_change_group_en_i)}})
          | {PBM_NPCH{!$past(sleep_input_off_i)}}
          | {2'h0, $past(external_irq_two_en_i), 2'h0})))
    else $error("pin-change input mismatch");
  a_irq_two: assert property ( // [R8]
    $past(external_irq_two_en_i) |->
      per_o.external_irq_two == $past(pad_in_i[PBM_PIN_IRQ2]))
    else $error("external irq two mismatch");
  a_clock_out: assert property ( // [R11]
    $past(clock_output_fuse_i) |-> pad_o.oe[PBM_PIN_CNT1]
      && pad_o.pv[PBM_PIN_CNT1] == $past(divided_sysclk_out_i))
    else $error("divided clock not on pin 1");
  a_usart_clock: assert property ( // [R13] [R14]
    !$past(serial_port_zero_sync_i) |-> !per_o.usart_zero_sync_clock)
    else $error("serial clock input outside sync mode");
  a_miso_in: assert property ( // [R16]
    master_seen |-> !pad_o.oe[PBM_PIN_MISO]
      && per_o.master_in == ($past(pad_in_i[PBM_PIN_MISO])
        && !$past(sleep_input_off_i)))
    else $error("MISO not input in master mode");

endmodule : pbm_mux

// [pbm_pins.sv]
// Pad and far-side level model for port B pins 6..0
`timescale 1ns/1ps
module pbm_pins
  import pbm_pkg::*;
(
  // Pad controls
  input  wire pbm_pad_s pad_i,
  // Outside drivers
  input  wire logic [PBM_NPINS-1:0] ext_i,
  input  wire logic [PBM_NPINS-1:0] ext_en_i,
  // Pad levels
  output logic [PBM_NPINS-1:0] level_o
);
  // Floating pins toggle off the edges so a stale level never passes
  logic flip = 1'h0;
  initial begin
    #3;
    forever #4 flip = ~flip;
  end
  always_comb begin
    for (int i = 0; i < PBM_NPINS; i++) begin
      if (pad_i.oe[i]) level_o[i] = pad_i.pv[i];
      else if (ext_en_i[i]) level_o[i] = ext_i[i];
      else if (pad_i.pu[i]) level_o[i] = 1'h1;
      else level_o[i] = flip;
    end
  end
endmodule : pbm_pins

// [port_b_alt_function_mux_tb.sv]
// Self-checking bench for the port B alternate-function mux
`timescale 1ns/1ps
module port_b_alt_function_mux_tb;
  import pbm_pkg::*;
  logic ref_clk_i = 1'h0;
  logic rst_i = 1'h1;
  pbm_port_s port_i;
  logic pud, slp, spe, mst, mo, so, ae, ao, be, bo, pge, i2e;
  logic fuse, dclk, syn, uco, s, m;
  logic [PBM_NPCH-1:0] msk;
  logic [PBM_NPINS-1:0] pad_in, ext, ext_en;
  pbm_pad_s pad_o, e_pad, k_pad;
  pbm_per_s per_o, e_per, k_per;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  integer seed = 32'hDEFF329F;
  always #2 ref_clk_i = ~ref_clk_i;
  pbm_mux u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .port_i(port_i),
    .pull_up_disable_i(pud), .sleep_input_off_i(slp), .pad_in_i(pad_in),
    .pad_o(pad_o), .spi_en_i(spe), .spi_master_i(mst),
    .spi_master_out_i(mo), .spi_slave_out_i(so),
    .timer_zero_compare_a_en_i(ae), .timer_zero_compare_a_out_i(ao),
    .timer_zero_compare_b_en_i(be), .timer_zero_compare_b_out_i(bo),
    .pin_change_group_en_i(pge), .pin_change_mask_i(msk),
    .external_irq_two_en_i(i2e), .clock_output_fuse_i(fuse),
    .divided_sysclk_out_i(dclk), .serial_port_zero_sync_i(syn),
    .usart_zero_sync_clock_out_i(uco), .per_o(per_o));
  pbm_pins u_pins (.pad_i(pad_o), .ext_i(ext), .ext_en_i(ext_en),
    .level_o(pad_in));
  // ----
  // Stimulus and reference model
  // ----
  task automatic drive();
    logic [31:0] r, t;
    r = $random(seed);
    t = $random(seed);
    port_i = pbm_port_s'(r[13:0]);
    {pud, slp, spe, mst, mo, so, ae, ao, be, bo} = r[23:14];
    {pge, i2e, fuse, dclk, syn, uco} = r[29:24];
    msk = t[4:0];
    ext = t[11:5];
    ext_en = t[18:12];
    if (rst_i) fuse = 1'h1;
  endtask : drive
  task automatic model();
    s = spe & ~mst;
    m = spe & mst;
    e_pad.oe = port_i.dir;
    e_pad.pv = port_i.out;
    e_pad.pu = port_i.out & ~port_i.dir & {PBM_NPINS{~pud}};
    e_pad.die = {PBM_NPINS{~slp}};
    if (s) e_pad.oe[5:4] = 2'h0;
    if (s) e_pad.pu[5:4] = port_i.out[5:4] & {2{~pud}};
    if (m) e_pad.oe[6] = 1'h0;
    if (m) e_pad.pu[6] = port_i.out[6] & ~pud;
    if (m) e_pad.pv[5] = mo;
    if (s) e_pad.pv[6] = so;
    if (be) e_pad.pv[4] = bo;
    if (ae) e_pad.pv[3] = ao;
    if (syn) e_pad.pv[0] = uco;
    if (fuse) e_pad.oe[1] = 1'h1;
    if (fuse) e_pad.pv[1] = dclk;
    e_pad.die[4:0] |= msk & {PBM_NPCH{pge}};
    e_pad.die[2] |= i2e;
    e_per.pin_change = pad_in[4:0] & e_pad.die[4:0];
    e_per.external_irq_two = pad_in[2] & e_pad.die[2];
    e_per.counter_one_ext_input = pad_in[1] & e_pad.die[1];
    e_per.counter_zero_ext_input = pad_in[0] & e_pad.die[0];
    e_per.usart_zero_sync_clock = syn & ~port_i.dir[0] & pad_in[0];
    e_per.sel_n = pad_in[4];
    e_per.slave_active = s & ~pad_in[4];
    e_per.master_in = m & pad_in[6];
    e_per.slave_in = s & pad_in[5];
    // Gating of these by sleep is left open, so they are only judged while their pin input is enabled
    k_pad = '1;
    k_pad.pu[1] = ~fuse;
    k_per = '1;
    k_per.master_in = ~slp;
    k_per.slave_in = ~slp;
    k_per.sel_n = ~slp;
    k_per.usart_zero_sync_clock = e_pad.die[0];
    if (rst_i) begin
      k_pad.pu[1] = 1'h0;
      e_pad.die = '1;
      e_pad.pu = '0;
      {e_pad.oe[6:2], e_pad.oe[0], e_pad.pv[6:2], e_pad.pv[0]} = '0;
      e_per = '0;
      e_per.sel_n = 1'h1;
      k_per = '1;
    end
  endtask : model
  task automatic chk_pad();
    samples_checked++;
    if ((pad_o & k_pad) !== (e_pad & k_pad)) begin
      miscompares++;
      $display("CHECK FAILED %0t pad %h exp %h", $time, pad_o & k_pad,
        e_pad & k_pad);
    end
  endtask : chk_pad
  task automatic chk_per();
    samples_checked++;
    if ((per_o & k_per) !== (e_per & k_per)) begin
      miscompares++;
      $display("CHECK FAILED %0t per %h exp %h", $time, per_o & k_per,
        e_per & k_per);
    end
  endtask : chk_per
  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // Second reset mid-run with the clock fuse set
  initial begin
    drive();
    for (int c = 0; c < 3000; c++) begin
      @(negedge ref_clk_i);
      if (c > 0) begin
        chk_pad();
        chk_per();
      end
      rst_i = c < 16 || (c >= 1500 && c < 1508);
      drive();
      #1 model();
    end
    tally_and_finish();
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      tally_and_finish();
    end
  end
endmodule : port_b_alt_function_mux_tb
